// ---- rtl/cit_decoder.sv ----
`timescale 1ns/1ps
module cit_decoder (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [7:0]  i_op1,
  input  wire logic [7:0]  i_op2,
  input  wire logic [15:0] i_next_pc,
  input  wire logic [7:0]  i_acc,
  input  wire logic [15:0] i_data_pointer_16,
  input  wire logic        i_carry,
  input  wire logic        i_bit_val,
  input  wire logic [7:0]  i_psw,
  input  wire logic [7:0]  i_r0,
  input  wire logic [7:0]  i_r1,
  input  wire logic [7:0]  i_cmp_val,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_known,
  output logic [1:0]       o_len,
  output logic [2:0]       o_cycles,
  output logic             o_branch,
  output logic             o_taken,
  output logic [15:0]      o_target,
  output logic [7:0]       o_bank_addr,
  output logic [7:0]       o_ind_addr,
  output logic             o_ind_upper,
  output logic             o_direct_sfr,
  output logic             o_clear_bit
);

  // ------------------------------------------------------------
  // length and base timing decode
  // ------------------------------------------------------------
  // returns {known, len, base cycles, conditional}
  function automatic logic [6:0] f_decode(input logic [7:0] op);
    logic [6:0] r;
    r = {1'b0, cit_pkg::LEN_1, cit_pkg::CYC_1, 1'b0};
    if (op[7:1] == cit_pkg::OPR_COPY_IND_ACC)
      r = {1'b1, cit_pkg::LEN_1, cit_pkg::CYC_2, 1'b0};
    else if (op[7:1] == cit_pkg::OPR_COPY_IND_DIR ||
             op[7:1] == cit_pkg::OPR_COPY_IND_IMM)
      r = {1'b1, cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b0};
    else if (op[7:1] == cit_pkg::OPR_XDT_RD_IND ||
             op[7:1] == cit_pkg::OPR_XDT_WR_IND)
      r = {1'b1, cit_pkg::LEN_1, cit_pkg::CYC_3, 1'b0};
    else if (op[7:1] == cit_pkg::OPR_SWAP_IND ||
             op[7:1] == cit_pkg::OPR_NIB_SWAP)
      r = {1'b1, cit_pkg::LEN_1, cit_pkg::CYC_2, 1'b0};
    else if (op[7:1] == cit_pkg::OPR_CMP_IND)
      r = {1'b1, cit_pkg::LEN_3, cit_pkg::CYC_4, 1'b1};
    else if (op[7:3] == cit_pkg::OPN_SWAP_RN)
      r = {1'b1, cit_pkg::LEN_1, cit_pkg::CYC_1, 1'b0};
    else if (op[7:3] == cit_pkg::OPN_CMP_RN)
      r = {1'b1, cit_pkg::LEN_3, cit_pkg::CYC_3, 1'b1};
    else if (op[7:3] == cit_pkg::OPN_DEC_RN)
      r = {1'b1, cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b1};
    else if (op[4:0] == cit_pkg::OPP_PAGE_CALL ||
             op[4:0] == cit_pkg::OPP_PAGE_BRANCH)
      r = {1'b1, cit_pkg::LEN_2, cit_pkg::CYC_3, 1'b0};
    else begin
      case (op)
        cit_pkg::OP_COPY_DIR_IMM,
        cit_pkg::OP_LOAD_DATA_POINTER_16:
          r = {1'b1, cit_pkg::LEN_3, cit_pkg::CYC_3, 1'b0};
        cit_pkg::OP_CODE_RD_DATA_POINTER_16, cit_pkg::OP_CODE_RD_PC,
        cit_pkg::OP_XDT_RD_DATA_POINTER_16, cit_pkg::OP_XDT_WR_DATA_POINTER_16,
        cit_pkg::OP_INDEXED:
          r = {1'b1, cit_pkg::LEN_1, cit_pkg::CYC_3, 1'b0};
        cit_pkg::OP_PUSH, cit_pkg::OP_POP, cit_pkg::OP_SWAP_DIR,
        cit_pkg::OP_ZERO_BIT, cit_pkg::OP_ONE_BIT, cit_pkg::OP_INV_BIT,
        cit_pkg::OP_AND_BIT, cit_pkg::OP_AND_NBIT, cit_pkg::OP_OR_BIT,
        cit_pkg::OP_OR_NBIT, cit_pkg::OP_COPY_C_BIT,
        cit_pkg::OP_COPY_BIT_C:
          r = {1'b1, cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b0};
        cit_pkg::OP_ZERO_C, cit_pkg::OP_ONE_C, cit_pkg::OP_INV_C,
        cit_pkg::OP_IDLE, cit_pkg::OP_IDLE_ALT:
          r = {1'b1, cit_pkg::LEN_1, cit_pkg::CYC_1, 1'b0};
        cit_pkg::OP_BR_C1, cit_pkg::OP_BR_C0, cit_pkg::OP_BR_AZ,
        cit_pkg::OP_BR_ANZ:
          r = {1'b1, cit_pkg::LEN_2, cit_pkg::CYC_2, 1'b1};
        cit_pkg::OP_BR_B1, cit_pkg::OP_BR_B0, cit_pkg::OP_BR_B1CLR,
        cit_pkg::OP_CMP_A_DIR, cit_pkg::OP_CMP_A_IMM,
        cit_pkg::OP_DEC_DIR:
          r = {1'b1, cit_pkg::LEN_3, cit_pkg::CYC_3, 1'b1};
        cit_pkg::OP_SHORT:
          r = {1'b1, cit_pkg::LEN_2, cit_pkg::CYC_3, 1'b0};
        cit_pkg::OP_FAR_CALL:
          r = {1'b1, cit_pkg::LEN_3, cit_pkg::CYC_4, 1'b0};
        cit_pkg::OP_FAR_BRANCH:
          r = {1'b1, cit_pkg::LEN_3, cit_pkg::CYC_4, 1'b0};
        default:
          r = {1'b0, cit_pkg::LEN_1, cit_pkg::CYC_1, 1'b0};
      endcase
    end
    return r;
  endfunction : f_decode

  // ------------------------------------------------------------
  // branch condition and target
  // ------------------------------------------------------------
  logic [6:0]  dec;
  logic        br;
  logic        tk;
  logic [15:0] tgt;
  logic [15:0] rel1;
  logic [15:0] rel2;
  logic        clr;

  // signed displacement onto next instruction address
  assign rel1 = i_next_pc + {{8{i_op1[7]}}, i_op1};
  assign rel2 = i_next_pc + {{8{i_op2[7]}}, i_op2};

  // decide taken and destination for each branching opcode
  always_comb begin
    dec = f_decode(i_opcode);
    br  = 1'b0;
    tk  = 1'b0;
    tgt = i_next_pc;
    clr = 1'b0;
    if (i_opcode[7:1] == cit_pkg::OPR_CMP_IND ||
        i_opcode[7:3] == cit_pkg::OPN_CMP_RN) begin
      br  = 1'b1;
      tk  = (i_cmp_val != i_op1);
      tgt = rel2;
    end else if (i_opcode[7:3] == cit_pkg::OPN_DEC_RN) begin
      br  = 1'b1;
      tk  = (i_cmp_val != cit_pkg::BYTE_ONE);
      tgt = rel1;
    end else if (i_opcode[4:0] == cit_pkg::OPP_PAGE_CALL ||
                 i_opcode[4:0] == cit_pkg::OPP_PAGE_BRANCH) begin
      br  = 1'b1;
      tk  = 1'b1;
      tgt = {i_next_pc[15:cit_pkg::PAGE_LO], i_opcode[7:5],
             i_op1};
    end else begin
      case (i_opcode)
        cit_pkg::OP_BR_C1: begin
          br = 1'b1; tk = i_carry; tgt = rel1;
        end
        cit_pkg::OP_BR_C0: begin
          br = 1'b1; tk = !i_carry; tgt = rel1;
        end
        cit_pkg::OP_BR_B1: begin
          br = 1'b1; tk = i_bit_val; tgt = rel2;
        end
        cit_pkg::OP_BR_B1CLR: begin
          br = 1'b1; tk = i_bit_val; tgt = rel2;
          clr = i_bit_val;
        end
        cit_pkg::OP_BR_B0: begin
          br = 1'b1; tk = !i_bit_val; tgt = rel2;
        end
        cit_pkg::OP_SHORT: begin
          br = 1'b1; tk = 1'b1; tgt = rel1;
        end
        cit_pkg::OP_INDEXED: begin
          br = 1'b1; tk = 1'b1; tgt = i_data_pointer_16 + {8'h00, i_acc};
        end
        cit_pkg::OP_BR_AZ: begin
          br = 1'b1; tk = (i_acc == cit_pkg::BYTE_ZERO); tgt = rel1;
        end
        cit_pkg::OP_BR_ANZ: begin
          br = 1'b1; tk = (i_acc != cit_pkg::BYTE_ZERO); tgt = rel1;
        end
        cit_pkg::OP_CMP_A_DIR: begin
          br = 1'b1; tk = (i_acc != i_cmp_val); tgt = rel2;
        end
        cit_pkg::OP_CMP_A_IMM: begin
          br = 1'b1; tk = (i_acc != i_op1); tgt = rel2;
        end
        cit_pkg::OP_DEC_DIR: begin
          br = 1'b1; tk = (i_cmp_val != cit_pkg::BYTE_ONE); tgt = rel2;
        end
        cit_pkg::OP_FAR_CALL, cit_pkg::OP_FAR_BRANCH: begin
          br = 1'b1; tk = 1'b1; tgt = {i_op1, i_op2};
        end
        default: begin
          br = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_EXEC} cit_state_t;
  cit_state_t  state, next_state;
  logic        accept;
  logic [2:0]  cnt, next_cnt, cyc;
  logic        next_busy, next_done;

  assign accept = i_start && !o_busy;
  // conditional ops add one cycle only when taken
  assign cyc = dec[3:1] + {2'h0, dec[0] & tk};

  // count out the instruction's cycles
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_busy  = o_busy;
    next_done  = o_done;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_EXEC;
          next_cnt   = cyc - cit_pkg::CYC_1;
          next_busy  = 1'b1;
          next_done  = (cyc == cit_pkg::CYC_1);
        end
      end
      ST_EXEC: begin
        next_cnt  = (cnt == cit_pkg::CYC_0) ? cnt : cnt - cit_pkg::CYC_1;
        next_done = (cnt == cit_pkg::CYC_1);
        if (cnt == cit_pkg::CYC_0) begin
          next_state = ST_IDLE;
          next_busy  = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_busy  = 1'b0;
        next_done  = 1'b0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state  <= ST_IDLE;
      cnt    <= cit_pkg::CYC_0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      state  <= next_state;
      cnt    <= next_cnt;
      o_busy <= next_busy;
      o_done <= next_done;
    end
  end

  // ------------------------------------------------------------
  // decoded results, held until the next accepted instruction
  // ------------------------------------------------------------
  logic [7:0] ind_a;
  assign ind_a = i_opcode[0] ? i_r1 : i_r0;

  // result registers load on accept
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_known      <= 1'b0;
      o_len        <= cit_pkg::LEN_1;
      o_cycles     <= cit_pkg::CYC_0;
      o_branch     <= 1'b0;
      o_taken      <= 1'b0;
      o_target     <= 16'h0000;
      o_bank_addr  <= 8'h00;
      o_ind_addr   <= 8'h00;
      o_ind_upper  <= 1'b0;
      o_direct_sfr <= 1'b0;
      o_clear_bit  <= 1'b0;
    end else if (i_ce && accept) begin
      o_known      <= dec[6];
      o_len        <= dec[5:4];
      o_cycles     <= cyc;
      o_branch     <= br;
      o_taken      <= tk;
      o_target     <= tgt;
      o_bank_addr  <= {cit_pkg::BANK_BASE,
        i_psw[cit_pkg::PSW_BANK_HI:cit_pkg::PSW_BANK_LO],
        i_opcode[2:0]};
      o_ind_addr   <= ind_a;
      o_ind_upper  <= ind_a[cit_pkg::SPACE_BIT];
      o_direct_sfr <= i_op1[cit_pkg::SPACE_BIT];
      o_clear_bit  <= clr;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic go;
  assign go = i_ce && accept;

  sequence s_three_run;
    $rose(o_busy) && o_cycles == cit_pkg::CYC_3 && i_ce ##1 i_ce;
  endsequence

  a_three_byte_imm: assert property (@(posedge i_clk) disable iff (!i_resetn)
    go && i_opcode == cit_pkg::OP_COPY_DIR_IMM |=>
      o_len == cit_pkg::LEN_3 && o_cycles == cit_pkg::CYC_3)
    else $error("direct immediate copy timing wrong");

  a_three_cycle_run: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_three_run |-> !o_done ##1 o_done)
    else $error("three cycle instruction ends at wrong cycle");

  a_idle_alias: assert property (@(posedge i_clk) disable iff (!i_resetn)
    go && i_opcode == cit_pkg::OP_IDLE_ALT |=>
      o_done && o_cycles == cit_pkg::CYC_1 && !o_branch)
    else $error("spare opcode not idle");

  a_carry_branch: assert property (@(posedge i_clk) disable iff (!i_resetn)
    go && i_opcode == cit_pkg::OP_BR_C1 |=>
      o_cycles == (o_taken ? cit_pkg::CYC_3 : cit_pkg::CYC_2))
    else $error("carry branch cycle count wrong");

  a_bit_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    go && i_opcode == cit_pkg::OP_BR_B1CLR && i_bit_val |=>
      o_clear_bit && o_taken && o_cycles == cit_pkg::CYC_4)
    else $error("bit branch did not clear bit");

  a_rel_target: assert property (@(posedge i_clk) disable iff (!i_resetn)
    go && i_opcode == cit_pkg::OP_SHORT |=>
      o_target == $past(i_next_pc) + {{8{$past(i_op1[7])}}, $past(i_op1)}
      && o_cycles == cit_pkg::CYC_3)
    else $error("short branch target wrong");

  a_page_keep: assert property (@(posedge i_clk) disable iff (!i_resetn)
    go && i_opcode[4:0] == cit_pkg::OPP_PAGE_BRANCH |=>
      o_target[15:11] == $past(i_next_pc[15:11]))
    else $error("page target left page");

  a_bank_select: assert property (@(posedge i_clk) disable iff (!i_resetn)
    go |=> o_bank_addr[4:3] == $past(i_psw[4:3]))
    else $error("bank select wrong");

  a_ind_compare: assert property (@(posedge i_clk) disable iff (!i_resetn)
    go && i_opcode[7:1] == cit_pkg::OPR_CMP_IND && i_cmp_val == i_op1
      |=> !o_taken && o_cycles == cit_pkg::CYC_4)
    else $error("indirect compare count wrong");

endmodule : cit_decoder

// ---- shared/cit_pkg.sv ----
// Operation
// - copy immediate to direct byte is three bytes, three cycles
// - writes to indirect ram take two cycles, one or two bytes
// - loading the 16-bit data pointer is three bytes, three cycles
// - code space reads at acc plus pointer or pc: one byte, three cycles
// - external data reads and writes are one byte, three cycles
// - stack push and pop of a direct byte: two bytes, two cycles
// - swap with bank register one cycle; direct, indirect, nibble two
// - carry ops one byte one cycle; direct bit ops two bytes two cycles
// - carry branches are two bytes, two or three cycles
// - bit branches three bytes, three or four; set variant clears bit
// - short branch is two bytes, three cycles
// - indexed indirect branch is one byte, three cycles
// - accumulator zero branches are two bytes, two or three cycles
// - compare branches three bytes; 3/4 cycles, indirect form 4/5
// - decrement branch: bank reg 2/3 two bytes, direct 3/4 three bytes
// - idle instruction one byte one cycle; 0xA5 behaves the same
// - displacement is signed 8-bit added to next instruction address
// - direct operand below 0x80 is data ram, above is special space
// - indirect address comes only from pointer register 0 or 1
// - bank register operand selects one of eight in current bank
// - page target keeps the 2K page of the next instruction
// - far target is a full 16-bit address
// - bank is chosen by status word bits 3 and 4
// - indirect addresses above 0x7F reach upper data ram
package cit_pkg;
  // single opcodes
  localparam logic [7:0] OP_COPY_DIR_IMM = 8'h75, OP_LOAD_DATA_POINTER_16 = 8'h90,
    OP_CODE_RD_DATA_POINTER_16 = 8'h93, OP_CODE_RD_PC = 8'h83, OP_XDT_RD_DATA_POINTER_16 = 8'hE0,
    OP_XDT_WR_DATA_POINTER_16 = 8'hF0, OP_PUSH = 8'hC0, OP_POP = 8'hD0,
    OP_SWAP_DIR = 8'hC5, OP_ZERO_C = 8'hC3, OP_ZERO_BIT = 8'hC2,
    OP_ONE_C = 8'hD3, OP_ONE_BIT = 8'hD2, OP_INV_C = 8'hB3,
    OP_INV_BIT = 8'hB2, OP_AND_BIT = 8'h82, OP_AND_NBIT = 8'hB0,
    OP_OR_BIT = 8'h72, OP_OR_NBIT = 8'hA0, OP_COPY_C_BIT = 8'hA2,
    OP_COPY_BIT_C = 8'h92, OP_BR_C1 = 8'h40, OP_BR_C0 = 8'h50,
    OP_BR_B1 = 8'h20, OP_BR_B0 = 8'h30, OP_BR_B1CLR = 8'h10,
    OP_FAR_CALL = 8'h12, OP_FAR_BRANCH = 8'h02, OP_SHORT = 8'h80,
    OP_INDEXED = 8'h73, OP_BR_AZ = 8'h60, OP_BR_ANZ = 8'h70,
    OP_CMP_A_DIR = 8'hB5, OP_CMP_A_IMM = 8'hB4, OP_DEC_DIR = 8'hD5,
    OP_IDLE = 8'h00, OP_IDLE_ALT = 8'hA5;
  // pointer register families, opcode bits 7..1
  localparam logic [6:0] OPR_COPY_IND_ACC = 7'h7B, OPR_COPY_IND_DIR = 7'h53,
    OPR_COPY_IND_IMM = 7'h3B, OPR_XDT_RD_IND = 7'h71,
    OPR_XDT_WR_IND = 7'h79, OPR_SWAP_IND = 7'h63, OPR_NIB_SWAP = 7'h6B,
    OPR_CMP_IND = 7'h5B;
  // bank register families, opcode bits 7..3
  localparam logic [4:0] OPN_SWAP_RN = 5'h19, OPN_CMP_RN = 5'h17,
    OPN_DEC_RN = 5'h1B;
  // page target families, opcode bits 4..0
  localparam logic [4:0] OPP_PAGE_CALL = 5'h11, OPP_PAGE_BRANCH = 5'h01;
  // lengths and cycle counts
  localparam logic [1:0] LEN_1 = 2'h1, LEN_2 = 2'h2, LEN_3 = 2'h3;
  localparam logic [2:0] CYC_0 = 3'h0, CYC_1 = 3'h1, CYC_2 = 3'h2,
    CYC_3 = 3'h3, CYC_4 = 3'h4, CYC_5 = 3'h5;
  // field positions
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_BANK_HI = 4;
  localparam int SPACE_BIT   = 7;
  localparam int PAGE_LO     = 11;
  localparam logic [7:0] BYTE_ONE = 8'h01, BYTE_ZERO = 8'h00;
  localparam logic [2:0] BANK_BASE = 3'h0;
endpackage : cit_pkg

// ---- tb/cit_decoder_bench.sv ----
`timescale 1ns/1ps
module cit_decoder_bench;
  // ----------------------------------
  // signals
  // ----------------------------------
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_start = 1'b0;
  logic        i_carry = 1'b0;
  logic        i_bit_val = 1'b0;
  logic [15:0] i_next_pc = 16'h0000;
  logic [15:0] i_data_pointer_16 = 16'h0000;
  logic [7:0]  i_acc = 8'h00;
  logic [7:0]  i_psw = 8'h00;
  logic [7:0]  i_cmp_val = 8'h00;
  logic [7:0]  opc, op1, op2, r0, r1, o_bank_addr, o_ind_addr;
  logic        o_busy, o_done, o_known, o_branch, o_taken;
  logic        o_ind_upper, o_direct_sfr, o_clear_bit;
  logic [1:0]  o_len;
  logic [2:0]  o_cycles;
  logic [15:0] o_target;
  logic [15:0] pc = 16'h0040;
  logic [15:0] data_pointer_16 = 16'h0000;
  logic [7:0]  acc = 8'h00;
  logic [7:0]  program_status_word = 8'h00;
  logic [7:0]  cv = 8'h00;
  logic        cy = 1'b0;
  logic        bv = 1'b0;
  int          fail_count = 0;
  int          compares = 0;
  // 200 MHz clock
  always #2.5 i_clk = ~i_clk;
  cit_decoder cit_decoder_i (
    .i_clk, .i_resetn, .i_ce, .i_start, .i_opcode(opc), .i_op1(op1),
    .i_op2(op2), .i_next_pc, .i_acc, .i_data_pointer_16, .i_carry, .i_bit_val,
    .i_psw, .i_r0(r0), .i_r1(r1), .i_cmp_val, .o_busy, .o_done, .o_known,
    .o_len, .o_cycles, .o_branch, .o_taken, .o_target, .o_bank_addr,
    .o_ind_addr, .o_ind_upper, .o_direct_sfr, .o_clear_bit);
  cit_mem_model cit_mem_model_i (
    .i_pc(pc), .i_psw, .o_opcode(opc), .o_op1(op1), .o_op2(op2),
    .o_r0(r0), .o_r1(r1));
  // ----------------------------------
  // compare and closing tasks
  // ----------------------------------
  task automatic chk_bit(input logic got, exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [15:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val
  task automatic end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------
  // instruction drivers
  // ----------------------------------
  // present one instruction, check length, busy span and done moment
  task automatic exec(input logic [7:0] op, b1, b2, input logic [1:0] len,
                      input logic [2:0] cyc);
    int n;
    cit_mem_model_i.put_code(pc, op, b1, b2);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_acc <= acc;
    i_data_pointer_16 <= data_pointer_16;
    i_carry <= cy;
    i_bit_val <= bv;
    i_psw <= program_status_word;
    i_cmp_val <= cv;
    i_next_pc <= pc + 16'(len);
    @(posedge i_clk);
    i_start <= 1'b0;
    #1;
    chk_bit(o_busy, 1'b1, "busy");
    chk_bit(o_known, 1'b1, "known");
    chk_val(16'(o_len), 16'(len), "len");
    chk_val(16'(o_cycles), 16'(cyc), "cycles out");
    n = 1;
    while (o_done !== 1'b1 && n < 8) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk_val(16'(n), 16'(cyc), "cycles to done");
    @(posedge i_clk);
    #1;
    chk_bit(o_busy, 1'b0, "busy end");
    chk_bit(o_done, 1'b0, "done pulse");
  endtask : exec
  // non-branch entry: opcode, length nibble, cycle nibble
  task automatic fx(input logic [15:0] e);
    exec(e[15:8], 8'h30, 8'h44, e[5:4], e[2:0]);
    chk_bit(o_branch, 1'b0, "no branch");
  endtask : fx
  // branch: base count plus one when taken, target from the last byte
  task automatic br(input logic [7:0] op, b1, b2, input logic [1:0] len,
                    input logic [2:0] base, input logic tk);
    logic [7:0]  r;
    logic [15:0] t;
    r = (len == 2'h2) ? b1 : b2;
    t = pc + 16'(len) + {{8{r[7]}}, r};
    exec(op, b1, b2, len, base + {2'h0, tk});
    chk_bit(o_branch, 1'b1, "branch");
    chk_bit(o_taken, tk, "taken");
    if (tk) chk_val(o_target, t, "rel");
  endtask : br
  // ----------------------------------
  // scenarios
  // ----------------------------------
  task automatic t_fixed;
    logic [15:0] tab [31] = '{16'h7533, 16'hF612, 16'hA622, 16'h7622,
      16'h9033, 16'h9313, 16'h8313, 16'hE213, 16'hF213, 16'hE013,
      16'hF013, 16'hC022, 16'hD022, 16'hC811, 16'hC522, 16'hC612,
      16'hD612, 16'hC311, 16'hC222, 16'hD311, 16'hD222, 16'hB311,
      16'hB222, 16'h8222, 16'hB022, 16'h7222, 16'hA022, 16'hA222,
      16'h9222, 16'h0011, 16'hA511};
    foreach (tab[k]) begin
      fx(tab[k]);
    end
  endtask : t_fixed
  task automatic t_cond;
    for (int k = 0; k < 2; k++) begin
      cy = k[0];
      bv = k[0];
      acc = k[0] ? 8'h00 : 8'h5A;
      br(8'h40, 8'h7F, 8'h00, 2'h2, 3'h2, cy);
      br(8'h50, 8'h80, 8'h00, 2'h2, 3'h2, !cy);
      br(8'h60, 8'hFE, 8'h00, 2'h2, 3'h2, cy);
      br(8'h70, 8'h01, 8'h00, 2'h2, 3'h2, !cy);
      br(8'h20, 8'h21, 8'h7F, 2'h3, 3'h3, bv);
      br(8'h30, 8'h21, 8'h80, 2'h3, 3'h3, !bv);
      br(8'h10, 8'h21, 8'hF0, 2'h3, 3'h3, bv);
      chk_bit(o_clear_bit, bv, "bit clear");
    end
  endtask : t_cond
  task automatic t_cmp;
    logic tk;
    for (int k = 0; k < 2; k++) begin
      tk = k[0];
      acc = 8'h33;
      cv = tk ? 8'h34 : 8'h33;
      br(8'hB5, 8'h40, 8'h10, 2'h3, 3'h3, tk);
      br(8'hB4, cv, 8'hF0, 2'h3, 3'h3, tk);
      br(8'hBA, 8'h33, 8'h10, 2'h3, 3'h3, tk);
      br(8'hB7, 8'h33, 8'h90, 2'h3, 3'h4, tk);
      cv = tk ? 8'h00 : 8'h01;
      br(8'hD9, 8'hFC, 8'h00, 2'h2, 3'h2, tk);
      br(8'hD5, 8'h50, 8'h06, 2'h3, 3'h3, tk);
    end
  endtask : t_cmp
  task automatic t_jump;
    br(8'h80, 8'h80, 8'h00, 2'h2, 3'h2, 1'b1);
    br(8'h80, 8'h7F, 8'h00, 2'h2, 3'h2, 1'b1);
    acc = 8'hF0;
    data_pointer_16 = 16'h1FF0;
    exec(8'h73, 8'h00, 8'h00, 2'h1, 3'h3);
    chk_val(o_target, 16'h20E0, "indexed");
    pc = 16'h07FE;
    exec(8'h61, 8'hAB, 8'h00, 2'h2, 3'h3);
    chk_val(o_target, 16'h0BAB, "page jump");
    exec(8'h51, 8'hCD, 8'h00, 2'h2, 3'h3);
    chk_val(o_target, 16'h0ACD, "page call");
    exec(8'h02, 8'h12, 8'h34, 2'h3, 3'h4);
    chk_val(o_target, 16'h1234, "far jump");
    exec(8'h12, 8'hFF, 8'hEE, 2'h3, 3'h4);
    chk_val(o_target, 16'hFFEE, "far call");
    pc = 16'h0040;
  endtask : t_jump
  task automatic t_oper;
    logic [1:0]  bb;
    logic [15:0] ex;
    for (int b = 0; b < 4; b++) begin
      bb = b[1:0];
      program_status_word = {3'h7, bb, 3'h7};
      cit_mem_model_i.put_ram({3'h0, bb, 3'h0}, {6'h04, bb});
      cit_mem_model_i.put_ram({3'h0, bb, 3'h1}, {6'h20, bb});
      exec({5'h19, bb, 1'b1}, 8'h00, 8'h00, 2'h1, 3'h1);
      ex = {11'h000, bb, bb, 1'b1};
      chk_val(16'(o_bank_addr), ex, "bank");
      exec(8'hF6, 8'h00, 8'h00, 2'h1, 3'h2);
      chk_val(16'(o_ind_addr), {10'h000, 4'h4, bb}, "ptr0");
      chk_bit(o_ind_upper, 1'b0, "lower");
      exec(8'hF7, 8'h00, 8'h00, 2'h1, 3'h2);
      chk_val(16'(o_ind_addr), {10'h002, 4'h0, bb}, "ptr1");
      chk_bit(o_ind_upper, 1'b1, "upper");
    end
    exec(8'hC0, 8'h7F, 8'h00, 2'h2, 3'h2);
    chk_bit(o_direct_sfr, 1'b0, "direct ram");
    exec(8'hC0, 8'h80, 8'h00, 2'h2, 3'h2);
    chk_bit(o_direct_sfr, 1'b1, "direct sfr");
  endtask : t_oper
  // clock enable low freezes a three cycle instruction
  task automatic t_hold;
    cit_mem_model_i.put_code(pc, 8'h75, 8'h30, 8'h44);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_next_pc <= pc + 16'h0003;
    @(posedge i_clk);
    i_start <= 1'b0;
    i_ce <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    chk_bit(o_busy, 1'b1, "frozen busy");
    chk_bit(o_done, 1'b0, "frozen done");
    @(posedge i_clk);
    i_ce <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk_bit(o_done, 1'b1, "done after thaw");
    @(posedge i_clk);
    #1;
    chk_bit(o_busy, 1'b0, "busy after thaw");
  endtask : t_hold
  // reset in mid instruction clears every result but len, which resets to one
  task automatic t_reset;
    cit_mem_model_i.put_code(pc, 8'h02, 8'h12, 8'h34);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_next_pc <= pc + 16'h0003;
    @(posedge i_clk);
    i_start <= 1'b0;
    i_resetn <= 1'b0;
    #1;
    chk_bit(o_busy, 1'b0, "busy in reset");
    chk_val(o_target, 16'h0000, "target in reset");
    chk_val(16'(o_len), 16'h0001, "len in reset");
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    chk_bit(o_busy, 1'b0, "busy after reset");
    chk_bit(o_known, 1'b0, "known after reset");
  endtask : t_reset
  // an opcode outside the set is flagged and lasts one cycle
  task automatic t_unknown;
    cit_mem_model_i.put_code(pc, 8'hFF, 8'h00, 8'h00);
    @(posedge i_clk);
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    #1;
    chk_bit(o_known, 1'b0, "unknown flagged");
    chk_bit(o_done, 1'b1, "unknown one cycle");
    @(posedge i_clk);
    #1;
    chk_bit(o_busy, 1'b0, "unknown end");
  endtask : t_unknown
  // ----------------------------------
  // main sequence and watchdog
  // ----------------------------------
  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    chk_val(16'(o_len), 16'h0001, "reset len");
    chk_bit(o_busy, 1'b0, "reset busy");
    t_fixed;
    t_cond;
    t_cmp;
    t_jump;
    t_oper;
    t_hold;
    t_reset;
    t_unknown;
    end_sim;
  end
  // cut a hang well past the expected run length
  initial begin
    repeat (5000) @(posedge i_clk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim;
  end
endmodule : cit_decoder_bench

// ---- tb/cit_mem_model.sv ----
`timescale 1ns/1ps
// ----------------------------------
// program and data memory model
// ----------------------------------
module cit_mem_model (
  input  wire logic [15:0] i_pc,
  input  wire logic [7:0]  i_psw,
  output logic      [7:0]  o_opcode,
  output logic      [7:0]  o_op1,
  output logic      [7:0]  o_op2,
  output logic      [7:0]  o_r0,
  output logic      [7:0]  o_r1
);
  logic [7:0] code [256];
  logic [7:0] ram  [256];
  logic [7:0] base;
  // unwritten code reads as all ones, ram as zero
  initial begin
    foreach (code[k]) code[k] = 8'hFF;
    foreach (ram[k]) ram[k] = 8'h00;
  end
  // three instruction bytes from the fetch address
  assign o_opcode = code[i_pc[7:0]];
  assign o_op1    = code[i_pc[7:0] + 8'h01];
  assign o_op2    = code[i_pc[7:0] + 8'h02];
  // pointer regs of the bank picked by status bits 4..3
  assign base = {3'h0, i_psw[4:3], 3'h0};
  assign o_r0 = ram[base];
  assign o_r1 = ram[base + 8'h01];
  // loaders used by the bench
  task automatic put_code(input logic [15:0] a, input logic [7:0] b0, b1, b2);
    code[a[7:0]] = b0;
    code[a[7:0] + 8'h01] = b1;
    code[a[7:0] + 8'h02] = b2;
  endtask : put_code
  task automatic put_ram(input logic [7:0] a, input logic [7:0] d);
    ram[a] = d;
  endtask : put_ram
endmodule : cit_mem_model
